// ---- core/cpl_pkg.sv ----
// Constants and types shared by the control pin logic
package cpl_pkg;
	localparam int          CLOCK_MHZ        = 250;
	// Double-rate clock periods from reset release to the first fetch
	localparam int          START_DELAY_DOUBLE_RATE_CLOCK = 400;
	localparam logic [8:0]  START_CYCLES     = 9'(START_DELAY_DOUBLE_RATE_CLOCK);
	localparam logic [7:0]  NMI_VECTOR       = 8'h02;
	localparam logic [23:0] RESET_FETCH_ADDR = 24'hff_fff0;
	// Internal phase two is every second double-rate clock
	localparam logic [0:0]  PHASE_RESET      = 1'h0;
	localparam logic [8:0]  COUNT_RESET      = 9'h000;

	typedef enum logic [1:0] {
		CPL_ST_RESET = 2'b00,
		CPL_ST_START = 2'b01,
		CPL_ST_RUN   = 2'b10
	} cpl_state_t;

	typedef enum logic [1:0] {
		CPL_BUS_IDLE = 2'b00,
		CPL_BUS_WAIT = 2'b01
	} cpl_bus_t;
endpackage

// ---- core/cpl_sync_if.sv ----
// Synchronised pin levels passed from the input stage to the core
`timescale 1ns/100ps
interface cpl_sync_if;
	logic nmi;
	logic reset;
	logic ready_n;
	logic coproc_req;
	logic nmi_q;
	logic reset_q;
	logic ready_n_q;
	logic coproc_req_q;
	modport src (output nmi, reset, ready_n, coproc_req,
		output nmi_q, reset_q, ready_n_q, coproc_req_q);
	modport dst (input nmi, reset, ready_n, coproc_req,
		input nmi_q, reset_q, ready_n_q, coproc_req_q);
endinterface

// ---- core/cpl_pin_sync.sv ----
// Three-stage pin synchronisers; a level counts when stages two and three agree
`timescale 1ns/100ps
module cpl_pin_sync (
	input  wire logic clock,
	input  wire logic resetn,
	input  wire logic nmi_pin,
	input  wire logic reset_pin,
	input  wire logic ready_n_pin,
	input  wire logic coproc_req_pin,
	cpl_sync_if.src   sync
);
	import cpl_pkg::*;

	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] stable;
	logic [3:0] next_stable;
	logic [3:0] pins;

	assign pins = {coproc_req_pin, ready_n_pin, reset_pin, nmi_pin};

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_bit
			always_comb begin
				next_stable[i] = (s2[i] == s3[i]) ? s3[i] : stable[i];
			end
			// Ready idles high, reset idles asserted until seen low
			always_ff @(posedge clock or negedge resetn) begin
				if (!resetn) begin
					s1[i]     <= (i == 1 || i == 2);
					s2[i]     <= (i == 1 || i == 2);
					s3[i]     <= (i == 1 || i == 2);
					stable[i] <= (i == 1 || i == 2);
				end else begin
					s1[i]     <= pins[i];
					s2[i]     <= s1[i];
					s3[i]     <= s2[i];
					stable[i] <= next_stable[i];
				end
			end
		end
	endgenerate

	assign sync.nmi          = next_stable[0];
	assign sync.reset        = next_stable[1];
	assign sync.ready_n      = next_stable[2];
	assign sync.coproc_req   = next_stable[3];
	assign sync.nmi_q        = stable[0];
	assign sync.reset_q      = stable[1];
	assign sync.ready_n_q    = stable[2];
	assign sync.coproc_req_q = stable[3];
endmodule

// ---- core/cpl_control.sv ----
// Control pin logic: NMI, coprocessor pacing, ready, reset start, SYSTEM_MANAGEMENT_MODE strobe
`timescale 1ns/100ps
module cpl_control (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        nmi_pin,
	input  wire logic        reset_pin,
	input  wire logic        ready_n_pin,
	input  wire logic        coproc_req_pin,
	input  wire logic [31:0] read_data_pin,
	input  wire logic        cycle_request,
	input  wire logic        cycle_smm,
	input  wire logic        interrupt_return_instr,
	input  wire logic        coproc_opcode_valid,
	input  wire logic [10:0] coproc_opcode,
	input  wire logic        hold_ack,
	input  wire logic        float_state,
	input  wire logic        mgmt_enable_bit,
	output logic             bus_cycle_addr_strobe_n,
	output logic             mgmt_memory_addr_strobe_n,
	output logic             mgmt_memory_addr_strobe_oe,
	output logic             cycle_done,
	output logic [31:0]      read_data,
	output logic             nmi_take,
	output logic [7:0]       nmi_vector,
	output logic             nmi_in_service,
	output logic             coproc_transfer_go,
	output logic [10:0]      coproc_opcode_held,
	output logic             fetch_start,
	output logic [23:0]      fetch_addr,
	output logic             in_reset,
	output logic             clock_doubled
);
	import cpl_pkg::*;

	cpl_sync_if sync ();

	cpl_pin_sync u_sync (
		.clock          (clock),
		.resetn         (resetn),
		.nmi_pin        (nmi_pin),
		.reset_pin      (reset_pin),
		.ready_n_pin    (ready_n_pin),
		.coproc_req_pin (coproc_req_pin),
		.sync           (sync)
	);

	// Reset sequencing and phase state
	cpl_state_t state;
	cpl_state_t next_state;
	logic [8:0] count;
	logic [8:0] next_count;
	logic       phase;
	logic       next_phase;
	logic       phase2;

	assign phase2 = (phase == 1'b1);

	always_comb begin
		next_state = state;
		next_count = count;
		next_phase = phase + 1'b1;
		if (sync.reset) begin
			next_state = CPL_ST_RESET;
			next_count = COUNT_RESET;
			next_phase = PHASE_RESET;
		end else begin
			case (state)
			CPL_ST_RESET: begin
				next_state = CPL_ST_START;
			end
			CPL_ST_START: begin
				next_count = count + 9'h001;
				if (count == START_CYCLES - 9'h001) begin
					next_state = CPL_ST_RUN;
				end
			end
			CPL_ST_RUN: begin
				next_state = CPL_ST_RUN;
			end
			default: begin
				next_state = CPL_ST_RESET;
			end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state <= CPL_ST_RESET;
			count <= COUNT_RESET;
			phase <= PHASE_RESET;
		end else begin
			state <= next_state;
			count <= next_count;
			phase <= next_phase;
		end
	end

	logic running;
	assign running = (state == CPL_ST_RUN) && !sync.reset;

	// NMI edge detection and service latch
	logic nmi_prev;
	logic next_nmi_prev;
	logic nmi_busy;
	logic next_nmi_busy;
	logic next_nmi_take;
	logic nmi_edge;

	// Sampled once per phase two so the edge spacing matches the pin timing
	assign nmi_edge = phase2 && sync.nmi && !nmi_prev;

	always_comb begin
		next_nmi_prev = nmi_prev;
		next_nmi_busy = nmi_busy;
		next_nmi_take = 1'b0;
		if (!running) begin
			// Track the level so a pin held high through reset is no edge
			next_nmi_prev = sync.nmi;
			next_nmi_busy = 1'b0;
		end else begin
			if (phase2) begin
				next_nmi_prev = sync.nmi;
			end
			if (interrupt_return_instr) begin
				next_nmi_busy = 1'b0;
			end
			// No mask term: only the service latch can hold an edge off
			// A return in the same cycle frees the latch for this edge
			if (nmi_edge && (!nmi_busy || interrupt_return_instr)) begin
				next_nmi_take = 1'b1;
				next_nmi_busy = 1'b1;
			end
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			nmi_prev       <= 1'b0;
			nmi_busy       <= 1'b0;
			nmi_take       <= 1'b0;
			nmi_in_service <= 1'b0;
			nmi_vector     <= 8'h00;
		end else begin
			nmi_prev       <= next_nmi_prev;
			nmi_busy       <= next_nmi_busy;
			nmi_take       <= next_nmi_take;
			nmi_in_service <= next_nmi_busy;
			nmi_vector     <= NMI_VECTOR;
		end
	end

	// Bus cycle: strobe, wait for ready, latch data
	cpl_bus_t   bus;
	cpl_bus_t   next_bus;
	logic       next_ads_n;
	logic       next_mgmt_memory_addr_strobe_n_n;
	logic       next_mgmt_memory_addr_strobe_n_oe;
	logic       next_done;
	logic [31:0] next_rdata;

	always_comb begin
		next_bus      = bus;
		next_ads_n    = 1'b1;
		next_mgmt_memory_addr_strobe_n_n  = 1'b1;
		next_done     = 1'b0;
		next_rdata    = read_data;
		// Strobe stays off the pin until enabled, and in hold or float
		next_mgmt_memory_addr_strobe_n_oe = running && mgmt_enable_bit
			&& !hold_ack && !float_state;
		if (!running) begin
			next_bus = CPL_BUS_IDLE;
		end else begin
			case (bus)
			CPL_BUS_IDLE: begin
				if (cycle_request && !hold_ack && !float_state) begin
					next_bus = CPL_BUS_WAIT;
					if (cycle_smm) begin
						next_mgmt_memory_addr_strobe_n_n = 1'b0;
					end else begin
						next_ads_n = 1'b0;
					end
				end
			end
			CPL_BUS_WAIT: begin
				// Ready ends both cycle kinds, SMM and normal; both are reads.
				// Only a fresh assertion counts: the synchronised ready of
				// the last cycle stays low for a few edges after it ends,
				// so ready must go high for two edges between cycles.
				if (!sync.ready_n && sync.ready_n_q) begin
					next_rdata = read_data_pin;
					next_done  = 1'b1;
					next_bus   = CPL_BUS_IDLE;
				end
			end
			default: begin
				next_bus = CPL_BUS_IDLE;
			end
			endcase
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			bus                        <= CPL_BUS_IDLE;
			bus_cycle_addr_strobe_n    <= 1'b1;
			mgmt_memory_addr_strobe_n  <= 1'b1;
			mgmt_memory_addr_strobe_oe <= 1'b0;
			cycle_done                 <= 1'b0;
			read_data                  <= 32'h0000_0000;
		end else begin
			bus                        <= next_bus;
			bus_cycle_addr_strobe_n    <= next_ads_n;
			mgmt_memory_addr_strobe_n  <= next_mgmt_memory_addr_strobe_n_n;
			mgmt_memory_addr_strobe_oe <= next_mgmt_memory_addr_strobe_n_oe;
			cycle_done                 <= next_done;
			read_data                  <= next_rdata;
		end
	end

	// Coprocessor opcode store and transfer pacing
	logic [10:0] next_opcode;
	logic        next_go;
	logic        next_fetch_start;
	logic        next_in_reset;

	always_comb begin
		next_opcode      = coproc_opcode_held;
		next_go          = 1'b0;
		next_fetch_start = (state == CPL_ST_START)
			&& (next_state == CPL_ST_RUN);
		next_in_reset    = (next_state != CPL_ST_RUN);
		if (running) begin
			if (coproc_opcode_valid) begin
				next_opcode = coproc_opcode;
			end
			next_go = sync.coproc_req;
		end
	end

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			coproc_opcode_held <= 11'h000;
			coproc_transfer_go <= 1'b0;
			fetch_start        <= 1'b0;
			fetch_addr         <= RESET_FETCH_ADDR;
			in_reset           <= 1'b1;
			clock_doubled      <= 1'b0;
		end else begin
			coproc_opcode_held <= next_opcode;
			coproc_transfer_go <= next_go;
			fetch_start        <= next_fetch_start;
			fetch_addr         <= RESET_FETCH_ADDR;
			in_reset           <= next_in_reset;
			clock_doubled      <= 1'b0;
		end
	end
endmodule

// ---- sim/cpl_control_asserts.sv ----
// Checker for the control pin logic outputs
`timescale 1ns/100ps
module cpl_control_asserts
	import cpl_pkg::*;
(
	input wire logic        clock,
	input wire logic        resetn,
	input wire logic        ready_n_pin,
	input wire logic [31:0] read_data_pin,
	input wire logic        hold_ack,
	input wire logic        float_state,
	input wire logic        mgmt_enable_bit,
	input wire logic        interrupt_return_instr,
	input wire logic        bus_cycle_addr_strobe_n,
	input wire logic        mgmt_memory_addr_strobe_n,
	input wire logic        mgmt_memory_addr_strobe_oe,
	input wire logic        cycle_done,
	input wire logic [31:0] read_data,
	input wire logic        nmi_take,
	input wire logic [7:0]  nmi_vector,
	input wire logic        nmi_in_service,
	input wire logic        fetch_start,
	input wire logic [23:0] fetch_addr,
	input wire logic        in_reset,
	input wire logic        clock_doubled
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);

	a_strobe_pulse: assert property (!bus_cycle_addr_strobe_n |=>
		bus_cycle_addr_strobe_n) else $error("strobe held too long");
	a_strobe_excl: assert property (!(!bus_cycle_addr_strobe_n &&
		!mgmt_memory_addr_strobe_n)) else $error("both strobes low");
	a_float_hold: assert property ((hold_ack || float_state)[*2] |->
		!mgmt_memory_addr_strobe_oe) else $error("strobe driven in hold");
	a_float_off: assert property ((!mgmt_enable_bit)[*2] |->
		!mgmt_memory_addr_strobe_oe) else $error("strobe driven disabled");
	a_nmi_vector: assert property (nmi_take |-> nmi_vector == NMI_VECTOR
		##1 nmi_in_service) else $error("bad nmi vector or service");
	a_nmi_block: assert property ((nmi_in_service &&
		!interrupt_return_instr)[*2] |=> !nmi_take)
		else $error("nmi taken in service");
	a_take_once: assert property (nmi_take |=> !nmi_take)
		else $error("nmi take longer than one cycle");
	a_reset_quiet: assert property (in_reset |->
		bus_cycle_addr_strobe_n && !nmi_take && !cycle_done &&
		!clock_doubled) else $error("activity during reset");
	a_fetch_addr: assert property (fetch_start |->
		fetch_addr == RESET_FETCH_ADDR) else $error("bad fetch address");
	a_done_data: assert property (cycle_done |->
		read_data == read_data_pin && $past(!ready_n_pin, 3))
		else $error("done without ready or data");

	c_nmi: cover property (nmi_take);
	c_smm: cover property (!mgmt_memory_addr_strobe_n);
	c_done: cover property (cycle_done);
	c_fetch: cover property (fetch_start);
endmodule
bind cpl_control cpl_control_asserts u_chk (
	.clock                      (clock),
	.resetn                     (resetn),
	.ready_n_pin                (ready_n_pin),
	.read_data_pin              (read_data_pin),
	.hold_ack                   (hold_ack),
	.float_state                (float_state),
	.mgmt_enable_bit            (mgmt_enable_bit),
	.interrupt_return_instr     (interrupt_return_instr),
	.bus_cycle_addr_strobe_n    (bus_cycle_addr_strobe_n),
	.mgmt_memory_addr_strobe_n  (mgmt_memory_addr_strobe_n),
	.mgmt_memory_addr_strobe_oe (mgmt_memory_addr_strobe_oe),
	.cycle_done                 (cycle_done),
	.read_data                  (read_data),
	.nmi_take                   (nmi_take),
	.nmi_vector                 (nmi_vector),
	.nmi_in_service             (nmi_in_service),
	.fetch_start                (fetch_start),
	.fetch_addr                 (fetch_addr),
	.in_reset                   (in_reset),
	.clock_doubled              (clock_doubled)
);

// ---- sim/cpl_bus_model.sv ----
// Bus controller stand-in: answers each strobe with ready and data
`timescale 1ns/100ps
module cpl_bus_model (
	input  wire logic        clock,
	input  wire logic        resetn,
	input  wire logic        strobe_n,
	input  wire logic        smm_strobe_n,
	input  wire logic        cycle_done,
	input  wire logic [31:0] word,
	input  wire logic [3:0]  delay,
	output logic             ready_n,
	output logic [31:0]      data
);
	logic       busy;
	logic [3:0] wait_cnt;

	always @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			busy     <= 1'b0;
			wait_cnt <= 4'h0;
			ready_n  <= 1'b1;
			data     <= 32'h0000_0000;
		end else if (!busy) begin
			// Idle bus shows the inverse so stale data cannot pass
			data <= ~word;
			if (!strobe_n || !smm_strobe_n) begin
				busy     <= 1'b1;
				wait_cnt <= delay;
			end
		end else if (cycle_done) begin
			busy    <= 1'b0;
			ready_n <= 1'b1;
			data    <= ~word;
		end else if (wait_cnt != 4'h0) begin
			wait_cnt <= wait_cnt - 4'h1;
		end else begin
			ready_n <= 1'b0;
			data    <= word;
		end
	end
endmodule

// ---- sim/cpl_control_tb_top.sv ----
// Self-checking bench for the control pin logic
`timescale 1ns/100ps
module cpl_control_tb_top;
	import cpl_pkg::*;
	logic clock, resetn, nmi_pin, reset_pin, ready_n_pin, coproc_req_pin;
	logic cycle_request, cycle_smm, interrupt_return_instr, hold_ack;
	logic coproc_opcode_valid, float_state, mgmt_enable_bit, cycle_done;
	logic bus_cycle_addr_strobe_n, mgmt_memory_addr_strobe_n, fetch_start;
	logic mgmt_memory_addr_strobe_oe, nmi_take, nmi_in_service, in_reset;
	logic coproc_transfer_go, clock_doubled;
	logic [31:0] read_data_pin, read_data, word;
	logic [10:0] coproc_opcode, coproc_opcode_held;
	logic [23:0] fetch_addr;
	logic [7:0]  nmi_vector;
	logic [3:0]  delay;
	logic [31:0] rd_q[$];
	logic [7:0]  nv_q[$];
	logic        sm_q[$];
	int          n_mismatch, cmp_count, seed, i, n;

	cpl_control DUT (.clock, .resetn, .nmi_pin, .reset_pin, .ready_n_pin,
		.coproc_req_pin, .read_data_pin, .cycle_request, .cycle_smm,
		.interrupt_return_instr, .coproc_opcode_valid, .coproc_opcode,
		.hold_ack, .float_state, .mgmt_enable_bit, .bus_cycle_addr_strobe_n,
		.mgmt_memory_addr_strobe_n, .mgmt_memory_addr_strobe_oe, .cycle_done,
		.read_data, .nmi_take, .nmi_vector, .nmi_in_service,
		.coproc_transfer_go, .coproc_opcode_held, .fetch_start, .fetch_addr,
		.in_reset, .clock_doubled);
	cpl_bus_model u_bus (.clock, .resetn, .strobe_n(bus_cycle_addr_strobe_n),
		.smm_strobe_n(mgmt_memory_addr_strobe_n), .cycle_done, .word, .delay,
		.ready_n(ready_n_pin), .data(read_data_pin));

	task automatic check(string what, logic [31:0] e, logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task automatic end_of_test;
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wait_hi(ref logic s, input int lim);
		n = 0;
		while (s !== 1'b1 && n < lim) begin
			@(negedge clock);
			n++;
		end
		if (s !== 1'b1) begin
			n_mismatch++;
			end_of_test();
		end
	endtask
	task automatic bus_read(input logic system_management_mode);
		word = $random(seed);
		delay = 4'($random(seed));
		rd_q.push_back(word);
		sm_q.push_back(system_management_mode);
		cycle_smm = system_management_mode;
		cycle_request = 1'b1;
		@(negedge clock);
		cycle_request = 1'b0;
		wait_hi(cycle_done, 60);
		@(negedge clock);
	endtask
	task automatic nmi_edge;
		nmi_pin = 1'b0;
		repeat (8) @(negedge clock);
		nmi_pin = 1'b1;
		repeat (8) @(negedge clock);
	endtask
	task automatic restart;
		reset_pin = 1'b0;
		wait_hi(fetch_start, 500);
		check("start delay", 1, 32'(n >= 395 && n <= 410));
		check("fetch_addr", 32'(RESET_FETCH_ADDR), 32'(fetch_addr));
		check("clock_doubled", 0, 32'(clock_doubled));
	endtask

	always @(negedge clock) begin
		if (cycle_done === 1'b1)
			check("read_data", rd_q.size() > 0 ? rd_q.pop_front() : 'x,
				read_data);
		if (nmi_take === 1'b1)
			check("nmi_vector", nv_q.size() > 0 ? 32'(nv_q.pop_front()) : 'x,
				32'(nmi_vector));
		if (bus_cycle_addr_strobe_n === 1'b0 ||
			mgmt_memory_addr_strobe_n === 1'b0)
			check("smm strobe", sm_q.size() > 0 ? 32'(sm_q.pop_front()) : 'x,
				32'(mgmt_memory_addr_strobe_n === 1'b0));
	end
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	initial begin
		#80000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		seed = 48834;
		{resetn, nmi_pin, cycle_request, cycle_smm, hold_ack} = '0;
		{interrupt_return_instr, coproc_opcode_valid, float_state} = '0;
		{coproc_req_pin, mgmt_enable_bit, word, delay} = '0;
		coproc_opcode = 11'h000;
		reset_pin = 1'b1;
		repeat (12) @(negedge clock);
		resetn = 1'b1;
		repeat (2) @(negedge clock);
		restart();
		check("mgmt_oe off", 0, 32'(mgmt_memory_addr_strobe_oe));
		mgmt_enable_bit = 1'b1;
		repeat (3) @(negedge clock);
		check("mgmt_oe on", 1, 32'(mgmt_memory_addr_strobe_oe));
		for (i = 0; i < 8; i++)
			bus_read(i[0]);
		hold_ack = 1'b1;
		repeat (3) @(negedge clock);
		check("mgmt_oe hold", 0, 32'(mgmt_memory_addr_strobe_oe));
		hold_ack = 1'b0;
		float_state = 1'b1;
		cycle_request = 1'b1;
		repeat (3) @(negedge clock);
		check("mgmt_oe float", 0, 32'(mgmt_memory_addr_strobe_oe));
		cycle_request = 1'b0;
		float_state = 1'b0;
		repeat (2) @(negedge clock);
		check("mgmt_oe back", 1, 32'(mgmt_memory_addr_strobe_oe));
		nv_q.push_back(NMI_VECTOR);
		nmi_edge();
		check("nmi_in_service", 1, 32'(nmi_in_service));
		nmi_edge();
		interrupt_return_instr = 1'b1;
		@(negedge clock);
		interrupt_return_instr = 1'b0;
		repeat (2) @(negedge clock);
		check("nmi_in_service", 0, 32'(nmi_in_service));
		nv_q.push_back(NMI_VECTOR);
		nmi_edge();
		coproc_opcode = 11'($random(seed));
		coproc_opcode_valid = 1'b1;
		@(negedge clock);
		coproc_opcode_valid = 1'b0;
		@(negedge clock);
		check("opcode", 32'(coproc_opcode), 32'(coproc_opcode_held));
		coproc_req_pin = 1'b1;
		wait_hi(coproc_transfer_go, 10);
		coproc_req_pin = 1'b0;
		repeat (8) @(negedge clock);
		check("coproc_go", 0, 32'(coproc_transfer_go));
		reset_pin = 1'b1;
		wait_hi(in_reset, 10);
		cycle_request = 1'b1;
		nmi_edge();
		cycle_request = 1'b0;
		@(negedge clock);
		restart();
		repeat (8) @(negedge clock);
		check("queues empty", 0,
			32'(rd_q.size() + nv_q.size() + sm_q.size()));
		end_of_test();
	end
endmodule
